/* rtl/output_disable_pkg.sv */
// Purpose: Shared constants and types for the output-disable request logic.
// Assumes: One 100 MHz clock that stands for the peripheral clock.
// Notes: Field positions and reset values are named here once.
package output_disable_pkg;

    localparam int unsigned NUM_REQ = 4;
    localparam int unsigned NUM_PAIR = 3;
    localparam int unsigned NUM_SEL = 12;
    localparam int unsigned SAMPLE_COUNT = 16;
    localparam logic [7:0] DIV_4 = 8'h04;
    localparam logic [7:0] DIV_16 = 8'h10;
    localparam logic [7:0] DIV_128 = 8'h80;

    typedef enum logic [1:0] {
        edge_accept_mode = 2'b00,
        sample_every_4_mode = 2'b01,
        sample_every_16_mode = 2'b10,
        sample_every_128_mode = 2'b11
    } accept_mode_t;

    typedef enum logic {
        active_level_low = 1'b0,
        active_level_high = 1'b1
    } active_level_t;

    localparam accept_mode_t MODE_RESET = edge_accept_mode;
    localparam logic IRQ_EN_RESET = 1'b0;
    localparam logic OSC_EN_RESET = 1'b0;

    // Per-input configuration carried together.
    typedef struct packed {
        accept_mode_t mode;
        logic irq_en;
    } req_cfg_t;

    // Paired outputs: a and b of each pair, first and second timer group.
    typedef struct packed {
        logic [NUM_PAIR-1:0] out_a;
        logic [NUM_PAIR-1:0] out_b;
    } pair_levels_t;

    function automatic logic [7:0] mode_divider(input accept_mode_t m);
        unique case (m)
            sample_every_4_mode: mode_divider = DIV_4;
            sample_every_16_mode: mode_divider = DIV_16;
            sample_every_128_mode: mode_divider = DIV_128;
            edge_accept_mode: mode_divider = DIV_4;
        endcase
    endfunction : mode_divider

endpackage : output_disable_pkg

/* rtl/request_acceptor.sv */
// Purpose: Accepts one active-low fault request by edge or by repeated low samples.
// Assumes: Input is already synchronised; tick_i pulses are per-mode strobes.
// Notes: accept_o is a one-cycle pulse.
`timescale 1ns/1ns
`default_nettype none
module request_acceptor
    import output_disable_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic req_n_i,
    input wire accept_mode_t mode_i,
    input wire logic [2:0] tick_i,
    output logic accept_o
);
    logic prev;
    logic [4:0] low_count;
    logic next_prev;
    logic [4:0] next_low_count;
    logic tick;

    always_comb begin
        unique case (mode_i)
            sample_every_4_mode: tick = tick_i[0];
            sample_every_16_mode: tick = tick_i[1];
            sample_every_128_mode: tick = tick_i[2];
            edge_accept_mode: tick = 1'b0;
        endcase
    end

    always_comb begin
        next_prev = req_n_i;
        next_low_count = low_count;
        accept_o = 1'b0;
        if (mode_i == edge_accept_mode) begin
            next_low_count = 5'h00;
            accept_o = prev & ~req_n_i;
        end else if (tick) begin
            if (req_n_i) begin
                next_low_count = 5'h00;
            end else if (low_count == 5'(SAMPLE_COUNT - 1)) begin
                next_low_count = 5'h00;
                accept_o = 1'b1;
            end else begin
                next_low_count = low_count + 5'h01;
            end
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            prev <= 1'b1;
            low_count <= 5'h00;
        end else begin
            prev <= next_prev;
            low_count <= next_low_count;
        end
    end
endmodule : request_acceptor
`default_nettype wire

/* rtl/output_disable_request_logic.sv */
// Summary of operation
// - Four active-low request inputs, each with own mode and interrupt enable.
// - Edge mode accepts a request on a high-to-low transition.
// - Mode four samples every 4 clocks, accepts after 16 low samples.
// - Mode sixteen samples every 16 clocks, accepts after 16 low samples.
// - Mode 128 samples every 128 clocks, accepts after 16 low samples.
// - Accepted request raises interrupt only when that input's enable is set.
// - After reset, all inputs use edge mode with interrupts disabled.
// - Enabled clock failure forces all protected outputs to high impedance.
// - Clock failure enable is clear after reset.
// - Each paired output has active level used for simultaneous-active detection.
// - Second group pairs reuse first group active levels.
// - Each protected output has a selector for its alternative physical pin.
//
// Purpose: Output-disable request logic for timer PWM output pins.
// Assumes: Configuration arrives as plain ports held steady by software.
// Notes: Request pins pass four flip-flops before use: three synchroniser stages, then the req_clean filter register.
`timescale 1ns/1ns
`default_nettype none
module output_disable_request_logic
    import output_disable_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic [NUM_REQ-1:0] fault_request_in_n_i,
    input wire logic clock_monitor_error_i,
    input wire req_cfg_t [NUM_REQ-1:0] req_cfg_i,
    input wire logic cfg_load_i,
    input wire logic osc_hiz_en_i,
    input wire logic [NUM_REQ-1:0] req_flag_clear_i,
    input wire logic osc_flag_clear_i,
    input wire pair_levels_t level_cfg_i,
    input wire logic level_load_i,
    input wire pair_levels_t group1_out_i,
    input wire pair_levels_t group2_out_i,
    input wire logic [NUM_SEL*2-1:0] pin_sel_i,
    output logic [NUM_REQ-1:0] req_flag_o,
    output logic [NUM_REQ-1:0] req_irq_o,
    output logic osc_flag_o,
    output logic hiz_o,
    output logic [NUM_PAIR-1:0] group1_both_active_o,
    output logic [NUM_PAIR-1:0] group2_both_active_o,
    output logic [NUM_SEL*2-1:0] pin_sel_o
);
    // Pin synchronisers: a change is taken once stages two and three agree.
    logic [NUM_REQ-1:0] sync1;
    logic [NUM_REQ-1:0] sync2;
    logic [NUM_REQ-1:0] sync3;
    logic [NUM_REQ-1:0] req_clean;
    logic [NUM_REQ-1:0] next_req_clean;
    logic osc1;
    logic osc2;
    logic osc3;

    req_cfg_t [NUM_REQ-1:0] cfg;
    req_cfg_t [NUM_REQ-1:0] next_cfg;
    logic osc_en;
    logic next_osc_en;
    pair_levels_t level;
    pair_levels_t next_level;
    logic [NUM_SEL*2-1:0] next_pin_sel;

    logic [6:0] div_count;
    logic [6:0] next_div_count;
    logic [2:0] tick;

    logic [NUM_REQ-1:0] accept;
    logic [NUM_REQ-1:0] next_req_flag;
    logic [NUM_REQ-1:0] next_req_irq;
    logic next_osc_flag;
    logic [NUM_PAIR-1:0] next_g1_both;
    logic [NUM_PAIR-1:0] next_g2_both;

    function automatic logic [NUM_PAIR-1:0] both_active(input pair_levels_t outs,
                                                        input pair_levels_t lv);
        // A pair counts as both active when each output equals its active level.
        both_active = ~(outs.out_a ^ lv.out_a) & ~(outs.out_b ^ lv.out_b);
    endfunction : both_active

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            sync1 <= {NUM_REQ{1'b1}};
            sync2 <= {NUM_REQ{1'b1}};
            sync3 <= {NUM_REQ{1'b1}};
            osc1 <= 1'b0;
            osc2 <= 1'b0;
            osc3 <= 1'b0;
        end else begin
            sync1 <= fault_request_in_n_i;
            sync2 <= sync1;
            sync3 <= sync2;
            osc1 <= clock_monitor_error_i;
            osc2 <= osc1;
            osc3 <= osc2;
        end
    end

    always_comb begin
        next_req_clean = req_clean;
        for (int i = 0; i < NUM_REQ; i++) begin
            if (sync2[i] == sync3[i]) begin
                next_req_clean[i] = sync3[i];
            end
        end
    end

    // Sampling strobes every 4, 16 and 128 clocks from one free-running divider.
    always_comb begin
        next_div_count = div_count + 7'h01;
        tick[0] = (div_count[1:0] == 2'h3);
        tick[1] = (div_count[3:0] == 4'hF);
        tick[2] = (div_count == 7'(DIV_128 - 8'h01));
    end

    always_comb begin
        next_cfg = cfg;
        next_osc_en = osc_en;
        next_level = level;
        next_pin_sel = pin_sel_o;
        if (cfg_load_i) begin
            next_cfg = req_cfg_i;
            next_osc_en = osc_hiz_en_i;
            next_pin_sel = pin_sel_i;
        end
        if (level_load_i) begin
            next_level = level_cfg_i;
        end
    end

    genvar g;
    generate
        for (g = 0; g < NUM_REQ; g++) begin : gen_req
            request_acceptor u_acceptor (
                .sys_clk_i(sys_clk_i),
                .rst_i(rst_i),
                .req_n_i(req_clean[g]),
                .mode_i(cfg[g].mode),
                .tick_i(tick),
                .accept_o(accept[g])
            );
        end
    endgenerate

    // Setting wins over a clear arriving in the same cycle.
    always_comb begin
        for (int i = 0; i < NUM_REQ; i++) begin
            next_req_flag[i] = accept[i] | (req_flag_o[i] & ~req_flag_clear_i[i]);
            next_req_irq[i] = accept[i] & cfg[i].irq_en;
        end
        // The failure only counts once stages two and three of its synchroniser agree.
        next_osc_flag = (osc_en & osc2 & osc3)
            | (osc_flag_o & ~osc_flag_clear_i);
        next_g1_both = both_active(group1_out_i, level);
        next_g2_both = both_active(group2_out_i, level);
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            req_clean <= {NUM_REQ{1'b1}};
            div_count <= 7'h00;
            for (int i = 0; i < NUM_REQ; i++) begin
                cfg[i].mode <= MODE_RESET;
                cfg[i].irq_en <= IRQ_EN_RESET;
            end
            osc_en <= OSC_EN_RESET;
            level <= '0;
            pin_sel_o <= '0;
            req_flag_o <= '0;
            req_irq_o <= '0;
            osc_flag_o <= 1'b0;
            group1_both_active_o <= '0;
            group2_both_active_o <= '0;
        end else begin
            req_clean <= next_req_clean;
            div_count <= next_div_count;
            cfg <= next_cfg;
            osc_en <= next_osc_en;
            level <= next_level;
            pin_sel_o <= next_pin_sel;
            req_flag_o <= next_req_flag;
            req_irq_o <= next_req_irq;
            osc_flag_o <= next_osc_flag;
            group1_both_active_o <= next_g1_both;
            group2_both_active_o <= next_g2_both;
        end
    end

    assign hiz_o = (|req_flag_o) | osc_flag_o;
endmodule : output_disable_request_logic
`default_nettype wire

/* tb/od_checker_assertions.sv */
// Purpose: Port checks for request acceptance, flags and selectors.
// Assumes: req_cfg_i and osc_hiz_en_i change only with a load strobe.
// Notes: Bound to the top module after the checker.
`timescale 1ns/1ns
`default_nettype none
module od_checker
    import output_disable_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic [NUM_REQ-1:0] fault_request_in_n_i,
    input wire logic clock_monitor_error_i,
    input wire req_cfg_t [NUM_REQ-1:0] req_cfg_i,
    input wire logic cfg_load_i,
    input wire logic osc_hiz_en_i,
    input wire logic [NUM_REQ-1:0] req_flag_clear_i,
    input wire logic osc_flag_clear_i,
    input wire logic [NUM_SEL*2-1:0] pin_sel_i,
    input wire logic [NUM_REQ-1:0] req_flag_o,
    input wire logic [NUM_REQ-1:0] req_irq_o,
    input wire logic osc_flag_o,
    input wire logic hiz_o,
    input wire logic [NUM_SEL*2-1:0] pin_sel_o
);
    logic [11:0] low_cnt;
    logic [11:0] next_low_cnt;
    logic [11:0] min_low;
    // Counts how long request 0 has been held low, saturating.
    always_comb begin
        next_low_cnt = (low_cnt == 12'hFFF) ? low_cnt : low_cnt + 12'h001;
        if (fault_request_in_n_i[0]) next_low_cnt = 12'h000;
    end
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) low_cnt <= 12'h000;
        else low_cnt <= next_low_cnt;
    end
    assign min_low = (req_cfg_i[0].mode == sample_every_4_mode) ? 12'h03C :
        (req_cfg_i[0].mode == sample_every_16_mode) ? 12'h0F0 : 12'h780;
    default clocking @(posedge sys_clk_i);
    endclocking
    default disable iff (rst_i);
    sequence s_fall0;
        $fell(fault_request_in_n_i[0]) && req_cfg_i[0].mode == edge_accept_mode;
    endsequence
    sequence s_taken0;
        ##[4:6] req_flag_o[0];
    endsequence
    a_edge_accept: assert property (s_fall0 |-> s_taken0)
        else $error("edge request late");
    a_sample_wait: assert property ($rose(req_flag_o[0]) &&
        req_cfg_i[0].mode != edge_accept_mode |-> low_cnt >= min_low)
        else $error("sampled request early");
    a_irq_enable: assert property ($rose(req_flag_o[0]) |->
        req_irq_o[0] == req_cfg_i[0].irq_en)
        else $error("irq does not follow enable");
    a_irq_pulse: assert property (|req_irq_o |=> (req_irq_o & $past(req_irq_o)) == 4'h0)
        else $error("irq longer than one cycle");
    a_flag_sticky: assert property (1'b1 |=>
        ($past(req_flag_o) & ~$past(req_flag_clear_i) & ~req_flag_o) == 4'h0)
        else $error("flag dropped without clear");
    a_osc_cause: assert property ($rose(osc_flag_o) |->
        osc_hiz_en_i && $past(clock_monitor_error_i, 3))
        else $error("osc flag without cause");
    a_hiz_sum: assert property (hiz_o == (|req_flag_o || osc_flag_o))
        else $error("hiz differs from flags");
    a_hiz_hold: assert property (hiz_o && req_flag_clear_i == 4'h0 && !osc_flag_clear_i
        |=> hiz_o)
        else $error("hiz dropped without clear");
    a_sel_load: assert property (cfg_load_i |=> pin_sel_o == $past(pin_sel_i))
        else $error("selector not loaded");
endmodule : od_checker
bind output_disable_request_logic od_checker u_chk (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .fault_request_in_n_i(fault_request_in_n_i),
    .clock_monitor_error_i(clock_monitor_error_i),
    .req_cfg_i(req_cfg_i),
    .cfg_load_i(cfg_load_i),
    .osc_hiz_en_i(osc_hiz_en_i),
    .req_flag_clear_i(req_flag_clear_i),
    .osc_flag_clear_i(osc_flag_clear_i),
    .pin_sel_i(pin_sel_i),
    .req_flag_o(req_flag_o),
    .req_irq_o(req_irq_o),
    .osc_flag_o(osc_flag_o),
    .hiz_o(hiz_o),
    .pin_sel_o(pin_sel_o)
);
`default_nettype wire

/* tb/fault_source.sv */
// Purpose: Far side: request pins, clock monitor and the pin mux.
// Assumes: Request pins have pull-ups, so a released pin reads high.
// Notes: The mux copy is compared with the selector by the bench.
`timescale 1ns/1ns
`default_nettype none
module fault_source
    import output_disable_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic [NUM_REQ-1:0] pull_i,
    input wire logic bad_i,
    input wire logic mux_load_i,
    input wire logic [NUM_SEL*2-1:0] mux_sel_i,
    output logic [NUM_REQ-1:0] req_n_o,
    output logic err_o,
    output logic [NUM_SEL*2-1:0] mux_o
);
    assign req_n_o = ~pull_i;
    assign err_o = bad_i;
    always_ff @(posedge sys_clk_i) begin
        if (mux_load_i) mux_o <= mux_sel_i;
    end
endmodule : fault_source
`default_nettype wire

/* tb/tb.sv */
// Purpose: Random and corner tests of the output-disable logic.
// Assumes: Inputs change at the falling edge.
// Notes: Expected delays come from the accept mode.
`timescale 1ns/1ns
`default_nettype none
module tb import output_disable_pkg::*;;
    logic sys_clk_i = 1'b0, rst_i = 1'b1, cfg_load_i = 1'b0, osc_hiz_en_i = 1'b0;
    logic osc_flag_clear_i = 1'b0, level_load_i = 1'b0, bad = 1'b0, clock_monitor_error_i;
    logic [3:0] req_flag_clear_i = 4'h0, pull = 4'h0, fault_request_in_n_i;
    logic [3:0] req_flag_o, req_irq_o;
    logic osc_flag_o, hiz_o;
    logic [2:0] group1_both_active_o, group2_both_active_o;
    logic [23:0] pin_sel_i = 24'h000000, pin_sel_o, mux;
    req_cfg_t [3:0] req_cfg_i = '0;
    pair_levels_t level_cfg_i = '0, group1_out_i = '0, group2_out_i = '0;
    int n_errors = 0, samples_checked = 0;
    always #5 sys_clk_i = ~sys_clk_i;
    output_disable_request_logic uut (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
        .fault_request_in_n_i(fault_request_in_n_i),
        .clock_monitor_error_i(clock_monitor_error_i), .req_cfg_i(req_cfg_i),
        .cfg_load_i(cfg_load_i), .osc_hiz_en_i(osc_hiz_en_i),
        .req_flag_clear_i(req_flag_clear_i), .osc_flag_clear_i(osc_flag_clear_i),
        .level_cfg_i(level_cfg_i), .level_load_i(level_load_i),
        .group1_out_i(group1_out_i), .group2_out_i(group2_out_i), .pin_sel_i(pin_sel_i),
        .req_flag_o(req_flag_o), .req_irq_o(req_irq_o), .osc_flag_o(osc_flag_o),
        .hiz_o(hiz_o), .group1_both_active_o(group1_both_active_o),
        .group2_both_active_o(group2_both_active_o), .pin_sel_o(pin_sel_o));
    fault_source far (.sys_clk_i(sys_clk_i), .pull_i(pull), .bad_i(bad),
        .mux_load_i(cfg_load_i), .mux_sel_i(pin_sel_i), .req_n_o(fault_request_in_n_i),
        .err_o(clock_monitor_error_i), .mux_o(mux));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk_i);
    endtask : cyc
    task tally_and_finish;
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : tally_and_finish
    function automatic int div_of(input accept_mode_t m);
        case (m)
            sample_every_4_mode: return 4;
            sample_every_16_mode: return 16;
            sample_every_128_mode: return 128;
            default: return 0;
        endcase
    endfunction : div_of
    function automatic logic [2:0] both(input pair_levels_t g, input pair_levels_t l);
        return ~(g.out_a ^ l.out_a) & ~(g.out_b ^ l.out_b);
    endfunction : both
    task automatic load_cfg;
        for (int j = 0; j < 12; j++) pin_sel_i[2*j +: 2] = 2'($urandom % 3);
        cfg_load_i = 1'b1;
        cyc(1);
        cfg_load_i = 1'b0;
        check(pin_sel_o, mux);
    endtask : load_cfg
    task automatic clr(input int i);
        req_flag_clear_i[i] = 1'b1;
        cyc(1);
        req_flag_clear_i[i] = 1'b0;
        cyc(1);
        check({req_flag_o, hiz_o}, 0);
    endtask : clr
    task automatic fire(input int i, input accept_mode_t m, input logic irq);
        int d;
        int k;
        d = div_of(m);
        k = 0;
        req_cfg_i[i] = '{mode: m, irq_en: irq};
        load_cfg();
        pull[i] = 1'b1;
        while (req_flag_o[i] !== 1'b1) begin
            cyc(1);
            k++;
            if (k > 2100) begin
                n_errors++;
                tally_and_finish();
            end
        end
        check(req_irq_o[i], irq);
        check({req_flag_o, hiz_o}, {4'h1 << i, 1'b1});
        check(k >= (d ? 15 * d : 4) && k <= (d ? 16 * d + 8 : 6), 1);
        if (d == 0) begin
            clr(i);
            cyc(20);
            check(req_flag_o[i], 0);
        end
        pull[i] = 1'b0;
        cyc(20);
        check(req_flag_o[i], d != 0);
        clr(i);
    endtask : fire
    initial begin
        void'($urandom(40));
        cyc(6);
        rst_i = 1'b0;
        check({req_flag_o, req_irq_o, osc_flag_o, hiz_o}, 0);
        bad = 1'b1;
        pull[0] = 1'b1;
        cyc(12);
        check({req_flag_o, osc_flag_o}, 5'h02);
        bad = 1'b0;
        pull[0] = 1'b0;
        clr(0);
        osc_hiz_en_i = 1'b1;
        load_cfg();
        bad = 1'b1;
        cyc(8);
        bad = 1'b0;
        cyc(10);
        check({osc_flag_o, hiz_o}, 2'h3);
        osc_flag_clear_i = 1'b1;
        cyc(1);
        osc_flag_clear_i = 1'b0;
        cyc(1);
        check(hiz_o, 0);
        $display("test reset and clock failure done");
        req_cfg_i[1] = '{mode: sample_every_4_mode, irq_en: 1'b1};
        load_cfg();
        for (int b = 0; b < 3; b++) begin
            pull[1] = b[0] ? 1'b0 : 1'b1;
            cyc(b[0] ? 8 : 50);
        end
        check(req_flag_o, 0);
        pull[1] = 1'b0;
        cyc(8);
        for (int r = 0; r < 16; r++) fire($urandom % 4, accept_mode_t'(2'(r)), 1'($urandom));
        $display("test request modes done");
        for (int r = 0; r < 8; r++) begin
            level_cfg_i = pair_levels_t'(6'($urandom));
            group1_out_i = pair_levels_t'(6'($urandom));
            group2_out_i = pair_levels_t'(6'($urandom));
            level_load_i = 1'b1;
            cyc(1);
            level_load_i = 1'b0;
            cyc(1);
            check(group1_both_active_o, both(group1_out_i, level_cfg_i));
            check(group2_both_active_o, both(group2_out_i, level_cfg_i));
        end
        $display("test active levels done");
        tally_and_finish();
    end
endmodule : tb
`default_nettype wire
